// ==== shared/sdl_defines.svh ====
// Constants for the serial converter word loader and its host
`ifndef SDL_DEFINES_SVH
`define SDL_DEFINES_SVH

// Word layout
`define SDL_WORD_BITS    16
`define SDL_CNT_BITS     5
`define SDL_CNT_ZERO     5'h00
`define SDL_CNT_ONE      5'h01
`define SDL_CNT_FULL     5'h10
`define SDL_SPD_BIT      14
`define SDL_PD_BIT       13
`define SDL_CODE_MSB     11
`define SDL_CODE_LSB     4
`define SDL_CODE_BITS    8
`define SDL_TAIL_ZERO    4'h0

// Reset values
`define SDL_WORD_RST     16'h0000
`define SDL_CODE_RST     8'h00

// Host timing: system clock and fastest legal shift clock, in MHz
`define SDL_CLK_MHZ      250
`define SDL_SCLK_MAX_MHZ 20
// Least half period of the shift clock in system cycles, rounded up
`define SDL_HALF_CYC     ((`SDL_CLK_MHZ + 2 * `SDL_SCLK_MAX_MHZ - 1) / (2 * `SDL_SCLK_MAX_MHZ))
`define SDL_DIV_BITS     8

// Host command registers (byte addresses)
`define SDL_ADDR_BITS    4
`define SDL_REG_CMD      4'h0
`define SDL_REG_STATUS   4'h4
`define SDL_REG_CTRL     4'h8
`define SDL_CTRL_3WIRE   0
`define SDL_CTRL_BYTE    1
`define SDL_BYTE_SPLIT   5'h08

`endif

// ==== shared/sdl_pkg.sv ====
// Types shared by both ends of the serial converter word loader
package sdl_pkg;
    `include "sdl_defines.svh"

    // Device: shift state, advanced on falling shift-clock edges
    typedef struct packed {
        logic [`SDL_WORD_BITS-1:0] shift;
        logic [`SDL_CNT_BITS-1:0]  count;
        logic                      seen;
    } sdl_shift_s;

    // Device: full-word load, on rising shift-clock edges
    typedef struct packed {
        logic [`SDL_WORD_BITS-1:0] word;
        logic                      taken;
        logic                      tgl;
    } sdl_load_s;

    // Device: early load, on rising frame-strobe edges
    typedef struct packed {
        logic [`SDL_WORD_BITS-1:0] word;
        logic                      tgl;
        logic                      frame_tgl;
    } sdl_early_s;

    // Device: system-clock side
    typedef struct packed {
        logic [2:0]                full_sync;
        logic [2:0]                early_sync;
        logic [`SDL_CODE_BITS-1:0] code;
        logic                      speed;
        logic                      pd;
        logic                      amp_off;
        logic                      update;
    } sdl_core_s;

    typedef enum logic [2:0] {
        SDL_IDLE, SDL_SELECT, SDL_FRAME, SDL_LOW, SDL_HIGH, SDL_GAP, SDL_END, SDL_DESEL
    } sdl_state_e;

    // Host state
    typedef struct packed {
        sdl_state_e                state;
        logic [`SDL_DIV_BITS-1:0]  cnt;
        logic [`SDL_CNT_BITS-1:0]  bits;
        logic [`SDL_WORD_BITS-1:0] word;
        logic [1:0]                ctrl;
        logic                      busy;
        logic                      sel_n;
        logic                      fs;
        logic                      sclk;
        logic                      sdata;
        logic [`SDL_WORD_BITS-1:0] rdata;
    } sdl_host_s;
endpackage

// ==== shared/sdl_if.sv ====
// Serial link between host port and converter loader
`timescale 1ns/1ns
`default_nettype none
interface sdl_if;
    logic sel_n;        // Device select, active low
    logic frame_strobe; // Falling edge starts a word
    logic sclk;         // Shift clock, made by the host
    logic sdata;        // Serial data, MSB first

    modport dev  (input sel_n, input frame_strobe, input sclk, input sdata);
    modport host (output sel_n, output frame_strobe, output sclk, output sdata);
endinterface
`default_nettype wire

// ==== design/sdl_device.sv ====
// Converter end: serial word loader with latch and control outputs
//
// How it works
// - Input accepted only with select low
// - Frame fall starts word, bits on falling edges
// - Sixteen bits or early frame rise loads latch
// - Reset clears every latch to zero
// - Select line picks device on shared port
// - Three-wire host may hold select low
// - Host without frame output makes edge itself
// - Byte-wide host sends two bytes per frame
// - Full word loads on next rising edge
// - Host shift clock at most 20 MHz
// - Top nibble control, lower twelve value
// - Code in bits eleven to four
// - Bit fourteen one selects fast settling
// - Bit thirteen one selects power-down
// - Power-down disables every amplifier
// - Latched code is unsigned eight-bit value
//
// Clock domains
// Falling shift clock: shift register and bit count
// Rising shift clock: full-word latch
// Rising frame strobe: early-load latch and frame marker
// System clock: synchronisers and output latches
//
// Crossings
// Each link-side latch flips a toggle when it loads
// The toggle passes two flops into the system clock
// The latched word is read only once its toggle lands
// A latch holds still until a later frame reloads it
// Only one toggle flips per frame
// Toggles reset to equal values, so no false load
// Loads closer than four system cycles may merge
//
// Frame handling
// Frame strobe falls are found at the first shift edge
// The frame marker flips on each selected frame rise
// A fall that sees a new marker starts a fresh word
// Bits after the sixteenth wait for a frame rise
// A rise after none or all sixteen bits loads nothing early
// An early word keeps its bits right-aligned
//
// Outputs
// dac_code holds bits eleven to four of the last word
// Speed and power-down hold bits fourteen and thirteen
// amp_disable follows the power-down bit
// update pulses for one cycle as they change
//
// Reset
// rst_b clears every domain, no shift clock needed
// The first word after reset needs no frame rise
// The shift clock idles high between frames
//
// Limitations
// Select must stay low from frame fall to its rise
// A frame rise with select high neither loads nor closes
// Data must settle before each falling shift-clock edge
// Twelve value bits carry an eight-bit code
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module sdl_device
    import sdl_pkg::*;
(
    sdl_if.dev                          link,
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    output logic [`SDL_CODE_BITS-1:0]   dac_code,
    output logic                        settle_speed_sel,
    output logic                        power_down_sel,
    output logic                        amp_disable,
    output logic                        update
);

    sdl_shift_s sh;
    sdl_shift_s next_sh;
    sdl_load_s  ld;
    sdl_load_s  next_ld;
    sdl_early_s er;
    sdl_early_s next_er;
    sdl_core_s  co;
    sdl_core_s  next_co;
    logic       new_word;   // Either toggle has landed
    logic       full_new;   // Full-word toggle has landed
    logic       early_new;  // Early-load toggle has landed
    logic       word_full;  // Sixteen bits are in the shift register
    logic       fresh_word; // Next captured bit starts a new word

    // Shift state helpers: word_full is read by all three link-side latches, fresh_word by the shift register only
    assign word_full  = (sh.count == `SDL_CNT_FULL);
    assign fresh_word = (sh.count == `SDL_CNT_ZERO) || (sh.seen != er.frame_tgl);

    // Link side, falling shift-clock edges: shift in one bit MSB first
    always_comb begin
        next_sh = sh;
        if (!link.sel_n && !link.frame_strobe) begin
            if (fresh_word) begin
                // First bit after a frame fall starts a fresh word
                next_sh.shift = {{(`SDL_WORD_BITS-1){1'b0}}, link.sdata};
                next_sh.count = `SDL_CNT_ONE;
                next_sh.seen  = er.frame_tgl;
            end else if (!word_full) begin
                // Later bits shift in behind; extras wait for a frame rise
                next_sh.shift = {sh.shift[`SDL_WORD_BITS-2:0], link.sdata};
                next_sh.count = sh.count + `SDL_CNT_ONE;
            end
        end
    end

    // Falling shift-clock register
    always_ff @(negedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            sh <= '0;
        end else begin
            sh <= next_sh;
        end
    end

    // Link side, rising shift-clock edges: load the full word once
    always_comb begin
        next_ld = ld;
        // Below sixteen bits the latch rearms for the next word
        if (!word_full) begin
            next_ld.taken = 1'b0;
        end else if (!link.sel_n && !ld.taken) begin
            next_ld.word  = sh.shift;
            next_ld.taken = 1'b1;
            next_ld.tgl   = ~ld.tgl;
        end
    end

    // Rising shift-clock register
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            ld <= '0;
        end else begin
            ld <= next_ld;
        end
    end

    // Frame-strobe rise: closes the frame, loads a partial word early
    always_comb begin
        next_er = er;
        if (!link.sel_n) begin
            next_er.frame_tgl = ~er.frame_tgl;
            // Partial word only; none or sixteen bits load nothing here
            if (sh.count != `SDL_CNT_ZERO && !word_full) begin
                next_er.word = sh.shift;
                next_er.tgl  = ~er.tgl;
            end
        end
    end

    // Frame-strobe register
    always_ff @(posedge link.frame_strobe or negedge rst_b) begin
        if (!rst_b) begin
            er <= '0;
        end else begin
            er <= next_er;
        end
    end

    // System side: take each loaded word across by toggle handshake
    assign full_new  = (co.full_sync[2] != co.full_sync[1]);
    assign early_new = (co.early_sync[2] != co.early_sync[1]);
    assign new_word  = full_new || early_new;

    // System side: synchronise both toggles, then latch the word
    always_comb begin
        logic [`SDL_WORD_BITS-1:0] w;
        // Full word first; one frame never flips both toggles
        w = full_new ? ld.word : er.word;
        next_co            = co;
        // Two flops before the compare stage
        next_co.full_sync  = {co.full_sync[1:0], ld.tgl};
        next_co.early_sync = {co.early_sync[1:0], er.tgl};
        // One-cycle pulse beside the new outputs
        next_co.update     = new_word;
        if (new_word) begin
            // Top and fourth control bits and the low nibble are ignored
            next_co.code    = w[`SDL_CODE_MSB:`SDL_CODE_LSB];
            next_co.speed   = w[`SDL_SPD_BIT];
            next_co.pd      = w[`SDL_PD_BIT];
            next_co.amp_off = w[`SDL_PD_BIT];
        end
    end

    // System-clock register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            co <= '0;
        end else begin
            co <= next_co;
        end
    end

    // Outputs straight from flops: code and control bits
    assign dac_code         = co.code;
    assign settle_speed_sel = co.speed;
    assign power_down_sel   = co.pd;

    // Amplifier disable and load pulse
    assign amp_disable      = co.amp_off;
    assign update           = co.update;

endmodule // sdl_device
`default_nettype wire

// ==== design/sdl_host.sv ====
// Host end: serial port that sends 16-bit words to the converter
`timescale 1ns/1ns
`default_nettype none
module sdl_host
    import sdl_pkg::*;
#(
    parameter logic [`SDL_DIV_BITS-1:0] HALF = `SDL_DIV_BITS'(`SDL_HALF_CYC) // Half shift-clock period in cycles
)(
    sdl_if.host                         link,
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic [`SDL_ADDR_BITS-1:0] addr,
    input  wire logic [`SDL_WORD_BITS-1:0] wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic [`SDL_WORD_BITS-1:0]   rdata
);

    sdl_host_s hs;
    sdl_host_s next_hs;
    logic      tick;

    assign tick = (hs.cnt == HALF - 1'b1);

    // Register port and link sequencer
    always_comb begin
        next_hs       = hs;
        next_hs.cnt   = tick ? '0 : hs.cnt + 1'b1;
        next_hs.rdata = '0;
        if (rd) begin
            unique case (addr)
                `SDL_REG_CMD:    next_hs.rdata = hs.word;
                `SDL_REG_STATUS: next_hs.rdata = {{(`SDL_WORD_BITS-1){1'b0}}, hs.busy};
                `SDL_REG_CTRL:   next_hs.rdata = {{(`SDL_WORD_BITS-2){1'b0}}, hs.ctrl};
                default:         next_hs.rdata = '0;
            endcase
        end
        if (wr && addr == `SDL_REG_CTRL && !hs.busy) begin
            next_hs.ctrl = wdata[1:0];
        end
        unique case (hs.state)
            SDL_IDLE: begin
                next_hs.sel_n = !hs.ctrl[`SDL_CTRL_3WIRE];
                if (wr && addr == `SDL_REG_CMD) begin
                    // Low nibble forced to zero on the wire
                    next_hs.word  = {wdata[`SDL_WORD_BITS-1:`SDL_CODE_LSB], `SDL_TAIL_ZERO};
                    next_hs.busy  = 1'b1;
                    next_hs.cnt   = '0;
                    next_hs.bits  = `SDL_CNT_ZERO;
                    next_hs.state = SDL_SELECT;
                end
            end
            SDL_SELECT: begin
                next_hs.sel_n = 1'b0;
                if (tick) next_hs.state = SDL_FRAME;
            end
            SDL_FRAME: begin
                if (tick) begin
                    next_hs.fs    = 1'b0;
                    next_hs.sdata = hs.word[`SDL_WORD_BITS-1];
                    next_hs.state = SDL_HIGH;
                end
            end
            SDL_HIGH: begin
                if (tick) begin
                    next_hs.sclk  = 1'b0;
                    next_hs.bits  = hs.bits + `SDL_CNT_ONE;
                    next_hs.state = SDL_LOW;
                end
            end
            SDL_LOW: begin
                if (tick) begin
                    next_hs.sclk  = 1'b1;
                    next_hs.word  = {hs.word[`SDL_WORD_BITS-2:0], 1'b0};
                    next_hs.sdata = hs.word[`SDL_WORD_BITS-2];
                    if (hs.bits == `SDL_CNT_FULL) next_hs.state = SDL_END;
                    else if (hs.bits == `SDL_BYTE_SPLIT && hs.ctrl[`SDL_CTRL_BYTE]) next_hs.state = SDL_GAP;
                    else next_hs.state = SDL_HIGH;
                end
            end
            SDL_GAP: begin
                // Pause between two byte writes, frame held low
                if (tick) next_hs.state = SDL_HIGH;
            end
            SDL_END: begin
                if (tick) begin
                    next_hs.fs    = 1'b1;
                    next_hs.state = SDL_DESEL;
                end
            end
            SDL_DESEL: begin
                if (tick) begin
                    next_hs.sel_n = !hs.ctrl[`SDL_CTRL_3WIRE];
                    next_hs.busy  = 1'b0;
                    next_hs.state = SDL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hs       <= '0;
            hs.state <= SDL_IDLE;
            hs.sel_n <= 1'b1;
            hs.fs    <= 1'b1;
            hs.sclk  <= 1'b1;
        end else begin
            hs <= next_hs;
        end
    end

    assign link.sel_n        = hs.sel_n;
    assign link.frame_strobe = hs.fs;
    assign link.sclk         = hs.sclk;
    assign link.sdata        = hs.sdata;
    assign rdata             = hs.rdata;

endmodule // sdl_host
`default_nettype wire

// ==== dv/sdl_link_sva.sv ====
// Checker for the serial link and the converter outputs
`timescale 1ns/1ns
`default_nettype none
`include "sdl_defines.svh"
module sdl_link_sva
    import sdl_pkg::*;
(
    input wire logic                      clock,
    input wire logic                      rst_b,
    input wire logic                      sel_n,
    input wire logic                      frame_strobe,
    input wire logic                      sclk,
    input wire logic                      sdata,
    input wire logic [`SDL_CODE_BITS-1:0] dac_code,
    input wire logic                      settle_speed_sel,
    input wire logic                      power_down_sel,
    input wire logic                      amp_disable,
    input wire logic                      update
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [4:0] fall_cnt;

    // Counts shift-clock falls inside the open frame
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            fall_cnt <= 5'h00;
        else if (frame_strobe)
            fall_cnt <= 5'h00;
        else if ($fell(sclk))
            fall_cnt <= fall_cnt + 5'h01;
    end

    frame_sel_a: assert property (!frame_strobe |-> !sel_n)
        else $error("frame open while device not selected");
    clk_idle_a: assert property (frame_strobe |-> sclk)
        else $error("shift clock low outside a frame");
    data_hold_a: assert property ($fell(sclk) |-> $stable(sdata))
        else $error("data moved at the capturing edge");
    tail_zero_a: assert property ($fell(sclk) && fall_cnt >= 5'h0c |-> !sdata)
        else $error("low four bits not sent as zero");
    bit_count_a: assert property (fall_cnt <= 5'h10)
        else $error("more than sixteen bits in a frame");
    low_width_a: assert property ($fell(sclk) |-> (!sclk) [*7])
        else $error("shift clock low phase too short");
    high_width_a: assert property ($rose(sclk) |-> sclk [*7])
        else $error("shift clock high phase too short");
    full_load_a: assert property ($rose(sclk) && !frame_strobe && fall_cnt == 5'h10 |-> ##[1:8] update)
        else $error("full word not loaded after sixteenth bit");
    load_only_a: assert property ($changed({dac_code, settle_speed_sel, power_down_sel}) |-> update)
        else $error("outputs changed without a load");
    upd_pulse_a: assert property (update |=> !update)
        else $error("update longer than one cycle");
    amp_off_a: assert property (amp_disable == power_down_sel)
        else $error("amplifier disable differs from power-down");
    reset_zero_a: assert property ($rose(rst_b) |-> dac_code == 8'h00 && !settle_speed_sel && !power_down_sel)
        else $error("outputs not cleared by reset");
endmodule // sdl_link_sva
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench: host drives one converter end, the bench drives a second one
`timescale 1ns/1ns
`default_nettype none
`include "sdl_defines.svh"
module testbench
    import sdl_pkg::*;
    ;
    logic        clock = 1'b0;
    logic        rst_b = 1'b1;
    logic [3:0]  addr  = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [15:0] rdata, rv;
    logic [7:0]  code1, code2;
    logic        spd1, pd1, amp1, upd1, spd2, pd2, amp2, upd2;
    int          n_fail = 0, n_checks = 0, n_upd1 = 0, n_upd2 = 0;
    logic [15:0] words[4] = '{16'h4ab0, 16'h2ff0, 16'h9000, 16'h601f};
    logic [15:0] mode_w[3] = '{16'h4a50, 16'h2b60, 16'h6c70};
    sdl_if l1();
    sdl_if l2();

    sdl_host sdl_host_i (.link(l1.host), .clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    sdl_device sdl_device_i (.link(l1.dev), .clock(clock), .rst_b(rst_b), .dac_code(code1),
        .settle_speed_sel(spd1), .power_down_sel(pd1), .amp_disable(amp1), .update(upd1));
    sdl_device sdl_device2_i (.link(l2.dev), .clock(clock), .rst_b(rst_b), .dac_code(code2),
        .settle_speed_sel(spd2), .power_down_sel(pd2), .amp_disable(amp2), .update(upd2));
    sdl_link_sva sdl_link_sva_i (.clock(clock), .rst_b(rst_b), .sel_n(l1.sel_n), .frame_strobe(l1.frame_strobe),
        .sclk(l1.sclk), .sdata(l1.sdata), .dac_code(code1), .settle_speed_sel(spd1),
        .power_down_sel(pd1), .amp_disable(amp1), .update(upd1));

    // System clock and load pulse counters
    always #2 clock = ~clock;
    always @(posedge clock) begin
        if (upd1 === 1'b1)
            n_upd1++;
        if (upd2 === 1'b1)
            n_upd2++;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_upd(input bit which, input int old);
        int i;
        for (i = 0; i < 3000 && (which ? n_upd2 : n_upd1) == old; i++)
            @(posedge clock);
        chk("update", 16'h0001, {15'h0000, (which ? n_upd2 : n_upd1) != old});
        #1;
    endtask

    task automatic check_out(input logic [15:0] w, input logic [7:0] c, input logic s, p, a);
        chk("dac_code", {8'h00, w[11:4]}, {8'h00, c});
        chk("settle_speed_sel", {15'h0000, w[14]}, {15'h0000, s});
        chk("power_down_sel", {15'h0000, w[13]}, {15'h0000, p});
        chk("amp_disable", {15'h0000, w[13]}, {15'h0000, a});
    endtask

    // Sends one word through the host, optionally with a second command while busy
    task automatic send_cmd(input logic [15:0] w, input bit extra);
        int i;
        int old;
        old = n_upd1;
        wr_reg(`SDL_REG_CMD, w);
        if (extra)
            wr_reg(`SDL_REG_CMD, ~w);
        rd_reg(`SDL_REG_CMD, rv);
        chk("cmd word", {w[15:4], 4'h0}, rv);
        chk("sel_n busy", 16'h0000, {15'h0000, l1.sel_n});
        rv = 16'h0001;
        for (i = 0; i < 400 && rv[0] !== 1'b0; i++)
            rd_reg(`SDL_REG_STATUS, rv);
        chk("busy", 16'h0000, rv);
        wait_upd(1'b0, old);
        check_out(w, code1, spd1, pd1, amp1);
        repeat (40) @(posedge clock);
        chk("update count", 16'(old + 1), 16'(n_upd1));
    endtask

    // Bench-made link at a 32 ns shift period; data line shows the inverse once released
    task automatic drv_frame(input logic [19:0] v, input int n, input logic sel);
        int i;
        #3 l2.sel_n = sel;
        #10 l2.frame_strobe = 1'b0;
        for (i = 0; i < n; i++) begin
            l2.sdata = v[19-i];
            #16 l2.sclk = 1'b0;
            #16 l2.sclk = 1'b1;
        end
        #16 l2.frame_strobe = 1'b1;
        #10 l2.sel_n = 1'b1;
        l2.sdata = ~l2.sdata;
    endtask

    task automatic finish_test();
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #200000;
        n_fail++;
        $display("BAD watchdog expected finish seen timeout");
        finish_test();
    end

    // Main sequence
    initial begin
        int m;
        int old;
        // A real falling reset edge clears every link-side domain
        rst_b <= 1'b0;
        l2.sel_n = 1'b1;
        l2.frame_strobe = 1'b1;
        l2.sclk = 1'b1;
        l2.sdata = 1'b0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        #1 check_out(16'h0000, code1, spd1, pd1, amp1);
        check_out(16'h0000, code2, spd2, pd2, amp2);
        rd_reg(`SDL_REG_CTRL, rv);
        chk("ctrl reset", 16'h0000, rv);
        rd_reg(4'hc, rv);
        chk("unmapped", 16'h0000, rv);
        foreach (words[i]) begin
            send_cmd(words[i], i == 1);
            chk("sel_n four-wire", 16'h0001, {15'h0000, l1.sel_n});
        end
        for (m = 1; m < 4; m++) begin
            wr_reg(`SDL_REG_CTRL, 16'(m));
            rd_reg(`SDL_REG_CTRL, rv);
            chk("ctrl", 16'(m), rv);
            send_cmd(mode_w[m-1], 1'b0);
            chk("sel_n mode", {15'h0000, ~m[0]}, {15'h0000, l1.sel_n});
        end
        wr_reg(`SDL_REG_CTRL, 16'h0000);
        drv_frame({16'h4ff0, 4'h0}, 16, 1'b1);
        repeat (20) @(posedge clock);
        chk("deselected updates", 16'h0000, 16'(n_upd2));
        check_out(16'h0000, code2, spd2, pd2, amp2);
        old = n_upd2;
        drv_frame({15'h2ab0, 5'h00}, 15, 1'b0);
        wait_upd(1'b1, old);
        check_out(16'h2ab0, code2, spd2, pd2, amp2);
        old = n_upd2;
        drv_frame({16'h4c30, 4'hf}, 20, 1'b0);
        wait_upd(1'b1, old);
        check_out(16'h4c30, code2, spd2, pd2, amp2);
        repeat (20) @(posedge clock);
        chk("extra bits updates", 16'(old + 1), 16'(n_upd2));
        finish_test();
    end
endmodule // testbench
`default_nettype wire
